// File: rtl/gpfs_top.sv
/*
 * Pin function select for eight GPIO ports: per-pin control of plain
 * I/O, analog use and peripheral alternate functions, plus pin data,
 * direction and interrupt detection.
 * Assumes configuration arrives on plain ports in the clk_i domain and
 * that pad inputs and the external reset pin are asynchronous.
 */
//
// Contract
// [R01] Peripheral routed only if select, enable, code match
// [R02] Cleared digital enable means analog, input cut
// [R03] Each pin's controls affect only that pin
// [R04] Other pins reset to tri-stated plain I/O; code resets them with digital enable cleared, so analog with input cut
// [R05] Power-on or external reset restores all defaults
// [R06] Serial and two-wire pins reset to code 0x1
// [R07] Debug pins reset with pull-up, code 0x3
// [R08] Eight independent ports A through H
// [R09] Maskable edge or level pin interrupts
// [R10] Address mask selects pin bits for data access
// [R11] Output may change every two clock cycles
// [R12] Plain I/O driven by direction and data registers
`timescale 1ns/1ps

module gpfs_top #(
  parameter int NPORT = gpfs_pkg::NPORT,
  parameter int NCODE = gpfs_pkg::NCODE
) (
  input  wire logic                              clk_i,         // System clock
  input  wire logic                              srst_i,        // Power-on reset
  input  wire logic                              ext_rst_i,     // Reset pin
  input  wire logic                              cfg_we_i,      // Write strobe
  input  wire logic [2:0]                        cfg_port_i,    // Port index
  input  wire gpfs_pkg::gpfs_reg_t               cfg_reg_i,     // Register
  input  wire logic [gpfs_pkg::NBIT-1:0]         cfg_mask_i,    // Bit mask
  input  wire logic [gpfs_pkg::PCTL_W-1:0]       cfg_wdata_i,   // Write data
  output logic      [gpfs_pkg::PCTL_W-1:0]       cfg_rdata_o,   // Read data
  input  wire logic [gpfs_pkg::NPIN-1:0]         pad_in_i,      // Pad level
  output logic      [gpfs_pkg::NPIN-1:0]         pad_out_o,     // Pad value
  output logic      [gpfs_pkg::NPIN-1:0]         pad_oe_o,      // Pad drive
  output logic      [gpfs_pkg::NPIN-1:0]         pad_pu_o,      // Pull-up
  output logic      [gpfs_pkg::NPIN-1:0]         pad_pd_o,      // Pull-down
  output logic      [gpfs_pkg::NPIN-1:0]         pad_din_en_o,  // Input buffer
  output logic      [gpfs_pkg::NPIN-1:0]         analog_en_o,   // Analog use
  input  wire logic [NCODE-1:0][gpfs_pkg::NPIN-1:0] periph_out_i, // Periph value
  input  wire logic [NCODE-1:0][gpfs_pkg::NPIN-1:0] periph_oe_i,  // Periph drive
  output logic      [NCODE-1:0][gpfs_pkg::NPIN-1:0] periph_sel_o, // Routed
  output logic      [gpfs_pkg::NPIN-1:0]         periph_in_o,   // Periph input
  output logic      [NPORT-1:0]                  irq_o          // Port irq
);

  localparam int NB = gpfs_pkg::NBIT;
  localparam int CW = gpfs_pkg::CODE_W;

  // ---------------------------------------------------------------
  // Reset and pad input synchronisers
  // ---------------------------------------------------------------
  logic [2:0]                   xrst_sync;
  logic                         xrst_q;
  logic                         rst;
  logic [gpfs_pkg::NPIN-1:0]    pin_s1, pin_s2, pin_s3, pin_filt;

  // Reset pin through three flops; counts once second and third agree
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      xrst_sync <= 3'h0;
      xrst_q    <= 1'b0;
    end else begin
      xrst_sync <= {xrst_sync[1:0], ext_rst_i};
      if (xrst_sync[1] == xrst_sync[2]) xrst_q <= xrst_sync[2];
    end
  end

  assign rst = srst_i | xrst_q; // [R05]

  // Pad levels: a change counts once second and third agree
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pin_s1   <= '0;
      pin_s2   <= '0;
      pin_s3   <= '0;
      pin_filt <= '0;
    end else begin
      pin_s1 <= pad_in_i;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      for (int i = 0; i < gpfs_pkg::NPIN; i++) begin
        if (pin_s2[i] == pin_s3[i]) pin_filt[i] <= pin_s3[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // Per-port register banks
  // ---------------------------------------------------------------
  logic [NB-1:0] data_q  [NPORT];
  logic [NB-1:0] dir_q   [NPORT];
  logic [NB-1:0] isns_q  [NPORT];
  logic [NB-1:0] iboth_q [NPORT];
  logic [NB-1:0] iev_q   [NPORT];
  logic [NB-1:0] imask_q [NPORT];
  logic [NB-1:0] iraw_q  [NPORT];
  logic [NB-1:0] afsel_q [NPORT];
  logic [NB-1:0] digen_q [NPORT];
  logic [NB-1:0] pdn_q   [NPORT];
  logic [NB-1:0] pup_q   [NPORT];
  logic [gpfs_pkg::PCTL_W-1:0] pctl_q [NPORT];
  logic [NB-1:0] pin_in  [NPORT];
  logic [NB-1:0] pin_prv [NPORT];

  for (genvar p = 0; p < NPORT; p++) begin : g_port // [R08]
    logic                        wr;
    logic [NB-1:0]               wd;
    logic [NB-1:0]               hit;
    logic [gpfs_pkg::PCTL_W-1:0] pctl_rst;
    logic [NB-1:0]               out_b;
    logic [NB-1:0]               oe_b;
    logic [NCODE-1:0][NB-1:0]    sel_b;

    assign wr = cfg_we_i && (cfg_port_i == 3'(p));
    assign wd = cfg_wdata_i[NB-1:0];
    assign pin_in[p] = pin_filt[p*NB +: NB];
    assign pctl_rst  = (p == 0) ? gpfs_pkg::PCTL_RST_A :
                       (p == 1) ? gpfs_pkg::PCTL_RST_B :
                       (p == 2) ? gpfs_pkg::PCTL_RST_C :
                                  gpfs_pkg::PCTL_RST_0;

    // Function select, enable, pull and mux code with reset defaults
    always_ff @(posedge clk_i) begin
      if (rst) begin // [R04] [R05] [R06] [R07]
        afsel_q[p] <= gpfs_pkg::AFSEL_RST[p*NB +: NB];
        digen_q[p] <= gpfs_pkg::DIGEN_RST[p*NB +: NB];
        pdn_q[p]   <= gpfs_pkg::PDN_RST[p*NB +: NB];
        pup_q[p]   <= gpfs_pkg::PUP_RST[p*NB +: NB];
        pctl_q[p]  <= pctl_rst;
      end else if (wr) begin
        case (cfg_reg_i)
          gpfs_pkg::GPFS_AFSEL: afsel_q[p] <= wd;
          gpfs_pkg::GPFS_DIGEN: digen_q[p] <= wd;
          gpfs_pkg::GPFS_PDN:   pdn_q[p]   <= wd;
          gpfs_pkg::GPFS_PUP:   pup_q[p]   <= wd;
          gpfs_pkg::GPFS_PCTL:  pctl_q[p]  <= cfg_wdata_i;
          default:              pctl_q[p]  <= pctl_q[p];
        endcase
      end
    end

    // Data and direction; data writes touch only masked bits
    always_ff @(posedge clk_i) begin
      if (rst) begin
        data_q[p] <= gpfs_pkg::BYTE_ZERO;
        dir_q[p]  <= gpfs_pkg::BYTE_ZERO;
      end else if (wr && cfg_reg_i == gpfs_pkg::GPFS_DATA) begin
        data_q[p] <= (data_q[p] & ~cfg_mask_i) | (wd & cfg_mask_i); // [R10] [R11]
      end else if (wr && cfg_reg_i == gpfs_pkg::GPFS_DIR) begin
        dir_q[p] <= wd;
      end
    end

    // Interrupt configuration
    always_ff @(posedge clk_i) begin
      if (rst) begin
        isns_q[p]  <= gpfs_pkg::BYTE_ZERO;
        iboth_q[p] <= gpfs_pkg::BYTE_ZERO;
        iev_q[p]   <= gpfs_pkg::BYTE_ZERO;
        imask_q[p] <= gpfs_pkg::BYTE_ZERO;
      end else if (wr) begin
        case (cfg_reg_i)
          gpfs_pkg::GPFS_ISENSE: isns_q[p]  <= wd;
          gpfs_pkg::GPFS_IBOTH:  iboth_q[p] <= wd;
          gpfs_pkg::GPFS_IEVENT: iev_q[p]   <= wd;
          gpfs_pkg::GPFS_IMASK:  imask_q[p] <= wd;
          default:               imask_q[p] <= imask_q[p];
        endcase
      end
    end

    // Edge or level detection; a new event beats a clear
    always_comb begin
      for (int b = 0; b < NB; b++) begin
        if (isns_q[p][b])
          hit[b] = (pin_in[p][b] == iev_q[p][b]);
        else if (iboth_q[p][b])
          hit[b] = (pin_in[p][b] != pin_prv[p][b]);
        else if (iev_q[p][b])
          hit[b] = pin_in[p][b] & ~pin_prv[p][b];
        else
          hit[b] = ~pin_in[p][b] & pin_prv[p][b];
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst) begin
        pin_prv[p] <= gpfs_pkg::BYTE_ZERO;
        iraw_q[p]  <= gpfs_pkg::BYTE_ZERO;
      end else begin
        pin_prv[p] <= pin_in[p];
        for (int b = 0; b < NB; b++) begin // [R09]
          if (isns_q[p][b])
            iraw_q[p][b] <= hit[b];
          else if (hit[b])
            iraw_q[p][b] <= 1'b1;
          else if (wr && cfg_reg_i == gpfs_pkg::GPFS_ICLR && wd[b])
            iraw_q[p][b] <= 1'b0;
        end
      end
    end

    assign irq_o[p] = |(iraw_q[p] & imask_q[p]); // [R09]

    // Pad and peripheral routing, one pin at a time, kept local per port
    always_comb begin
      for (int b = 0; b < NB; b++) begin // [R03]
        for (int c = 0; c < NCODE; c++) begin
          sel_b[c][b] = afsel_q[p][b] && digen_q[p][b] &&
            (pctl_q[p][b*CW +: CW] == CW'(c)); // [R01]
        end
        out_b[b] = 1'b0;
        oe_b[b]  = 1'b0;
        if (!afsel_q[p][b] && digen_q[p][b]) begin // [R12]
          out_b[b] = data_q[p][b];
          oe_b[b]  = dir_q[p][b];
        end else if (afsel_q[p][b] && digen_q[p][b]) begin // [R01] [R12]
          out_b[b] = periph_out_i[pctl_q[p][b*CW +: CW]][p*NB+b];
          oe_b[b]  = periph_oe_i[pctl_q[p][b*CW +: CW]][p*NB+b];
        end
      end
    end

    // Each port drives only its own slice of the pin vectors
    for (genvar c = 0; c < NCODE; c++) begin : g_code
      assign periph_sel_o[c][p*NB +: NB] = sel_b[c];
    end
    assign pad_out_o[p*NB +: NB]    = out_b;
    assign pad_oe_o[p*NB +: NB]     = oe_b;
    assign pad_pu_o[p*NB +: NB]     = pup_q[p];
    assign pad_pd_o[p*NB +: NB]     = pdn_q[p];
    assign pad_din_en_o[p*NB +: NB] = digen_q[p];
    assign analog_en_o[p*NB +: NB]  = ~digen_q[p]; // [R02]
    assign periph_in_o[p*NB +: NB]  = pin_in[p] & digen_q[p]; // [R02]
  end

  // ---------------------------------------------------------------
  // Read back, registered; data reads see only masked bits
  // ---------------------------------------------------------------
  logic [gpfs_pkg::PCTL_W-1:0] next_rdata;
  logic [NB-1:0]               pin_view;

  always_comb begin
    pin_view   = (pin_in[cfg_port_i] & ~dir_q[cfg_port_i]) |
                 (data_q[cfg_port_i] & dir_q[cfg_port_i]);
    next_rdata = '0;
    case (cfg_reg_i)
      gpfs_pkg::GPFS_DATA:   next_rdata[NB-1:0] = pin_view & cfg_mask_i; // [R10]
      gpfs_pkg::GPFS_DIR:    next_rdata[NB-1:0] = dir_q[cfg_port_i];
      gpfs_pkg::GPFS_ISENSE: next_rdata[NB-1:0] = isns_q[cfg_port_i];
      gpfs_pkg::GPFS_IBOTH:  next_rdata[NB-1:0] = iboth_q[cfg_port_i];
      gpfs_pkg::GPFS_IEVENT: next_rdata[NB-1:0] = iev_q[cfg_port_i];
      gpfs_pkg::GPFS_IMASK:  next_rdata[NB-1:0] = imask_q[cfg_port_i];
      gpfs_pkg::GPFS_IRAW:   next_rdata[NB-1:0] = iraw_q[cfg_port_i];
      gpfs_pkg::GPFS_IMSK:   next_rdata[NB-1:0] =
                               iraw_q[cfg_port_i] & imask_q[cfg_port_i];
      gpfs_pkg::GPFS_AFSEL:  next_rdata[NB-1:0] = afsel_q[cfg_port_i];
      gpfs_pkg::GPFS_DIGEN:  next_rdata[NB-1:0] = digen_q[cfg_port_i];
      gpfs_pkg::GPFS_PDN:    next_rdata[NB-1:0] = pdn_q[cfg_port_i];
      gpfs_pkg::GPFS_PUP:    next_rdata[NB-1:0] = pup_q[cfg_port_i];
      gpfs_pkg::GPFS_PCTL:   next_rdata = pctl_q[cfg_port_i];
      default:               next_rdata = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst) cfg_rdata_o <= '0;
    else     cfg_rdata_o <= next_rdata;
  end

endmodule : gpfs_top

// File: pkg/gpfs_pkg.sv
/*
 * Constants for the pin function select block: register select codes,
 * widths and reset defaults of the per-pin control fields.
 * Assumes pin index = port * 8 + bit, with port A = 0 up to port H = 7.
 */
package gpfs_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int NPORT      = 8;
  localparam int NBIT       = 8;
  localparam int NPIN       = NPORT * NBIT;
  localparam int CODE_W     = 4;
  localparam int NCODE      = 16;
  localparam int PCTL_W     = NBIT * CODE_W;

  // ---------------------------------------------------------------
  // Register select codes on the configuration port
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    GPFS_DATA   = 4'h0,
    GPFS_DIR    = 4'h1,
    GPFS_ISENSE = 4'h2,
    GPFS_IBOTH  = 4'h3,
    GPFS_IEVENT = 4'h4,
    GPFS_IMASK  = 4'h5,
    GPFS_IRAW   = 4'h6,
    GPFS_IMSK   = 4'h7,
    GPFS_ICLR   = 4'h8,
    GPFS_AFSEL  = 4'h9,
    GPFS_DIGEN  = 4'hA,
    GPFS_PDN    = 4'hB,
    GPFS_PUP    = 4'hC,
    GPFS_PCTL   = 4'hD
  } gpfs_reg_t;

  // ---------------------------------------------------------------
  // Reset defaults (serial, two-wire and debug pins leave reset assigned)
  // ---------------------------------------------------------------
  localparam logic [NPIN-1:0]   AFSEL_RST = 64'h0000_0000_000F_0C3F;
  localparam logic [NPIN-1:0]   DIGEN_RST = 64'h0000_0000_000F_0C3F;
  localparam logic [NPIN-1:0]   PDN_RST   = 64'h0000_0000_0000_0000;
  localparam logic [NPIN-1:0]   PUP_RST   = 64'h0000_0000_000F_0000;
  localparam logic [PCTL_W-1:0] PCTL_RST_A = 32'h0011_1111;
  localparam logic [PCTL_W-1:0] PCTL_RST_B = 32'h0000_1100;
  localparam logic [PCTL_W-1:0] PCTL_RST_C = 32'h0000_3333;
  localparam logic [PCTL_W-1:0] PCTL_RST_0 = 32'h0000_0000;
  localparam logic [NBIT-1:0]   BYTE_ZERO  = 8'h00;

endpackage : gpfs_pkg

// File: dv/gpfs_far_model.sv
/* Far side of the pins: pad levels and peripheral signals.
   Pad levels come from the bench; peripheral values move each cycle. */
`timescale 1ns/1ps
module gpfs_far_model (
  input  wire logic             clk_i,     // System clock
  input  wire logic [63:0]      lvl_i,     // Wanted pad levels
  output logic      [63:0]      pad_in_o,  // Pad levels
  output logic [15:0][63:0]     per_out_o, // Peripheral values
  output logic [15:0][63:0]     per_oe_o   // Peripheral drives
);
  logic [7:0] cnt = 8'h00;
  // Free count so a stale route shows up
  always @(posedge clk_i) cnt <= cnt + 8'h01;
  // Distinct value and drive pattern per code
  always_comb begin
    pad_in_o = lvl_i;
    for (int c = 0; c < 16; c++) begin
      per_out_o[c] = {8{cnt ^ 8'(c)}};
      per_oe_o[c]  = ~{8{cnt ^ 8'(c * 5)}};
    end
  end
endmodule : gpfs_far_model

// File: dv/gpfs_top_assertions.sv
/* Port checker for gpfs_top.
   Bound into every gpfs_top instance. */
`timescale 1ns/1ps
module gpfs_top_assertions #(parameter int NPORT = 8, NCODE = 16) (
  input wire logic                   clk_i,        // Clock
  input wire logic                   srst_i,       // Reset
  input wire logic                   ext_rst_i,    // Reset pin
  input wire logic                   cfg_we_i,     // Write strobe
  input wire logic [2:0]             cfg_port_i,   // Port
  input wire gpfs_pkg::gpfs_reg_t    cfg_reg_i,    // Register
  input wire logic [31:0]            cfg_wdata_i,  // Write data
  input wire logic [63:0]            pad_oe_o,     // Pad drive
  input wire logic [63:0]            pad_pu_o,     // Pull-up
  input wire logic [63:0]            pad_din_en_o, // Input buffer
  input wire logic [63:0]            analog_en_o,  // Analog use
  input wire logic [63:0]            periph_in_o,  // Periph input
  input wire logic [NCODE-1:0][63:0] periph_oe_i,  // Periph drive
  input wire logic [NCODE-1:0][63:0] periph_sel_o  // Routed
);
  logic [63:0] sel_any;
  logic [63:0] sel_oe;
  // Union of routes and the drive they ask for
  always_comb begin
    sel_any = '0;
    sel_oe = '0;
    for (int c = 0; c < NCODE; c++) begin
      sel_any |= periph_sel_o[c];
      sel_oe |= periph_sel_o[c] & periph_oe_i[c];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  a_route_needs_dig: assert property ((sel_any & ~pad_din_en_o) == '0)
    else $error("route on pin without digital enable");
  a_analog_inverse: assert property (analog_en_o == ~pad_din_en_o)
    else $error("analog use not inverse of enable");
  a_input_cut: assert property ((periph_in_o & ~pad_din_en_o) == '0)
    else $error("input path open on analog pin");
  a_route_drive: assert property ((sel_any & (pad_oe_o ^ sel_oe)) == '0)
    else $error("routed pin drive not from peripheral");
  a_reset_pads: assert property ($past(srst_i) |->
    pad_din_en_o == 64'h0000_0000_000F_0C3F && pad_pu_o == 64'h000F_0000)
    else $error("pad defaults wrong after reset");
  a_reset_route: assert property ($past(srst_i) |->
    periph_sel_o[1] == 64'h0C3F && periph_sel_o[3] == 64'h000F_0000)
    else $error("reset routing wrong");
  a_write_dig: assert property (cfg_we_i && !$past(ext_rst_i, 3) &&
    !$past(ext_rst_i, 4) && cfg_reg_i == gpfs_pkg::GPFS_DIGEN |=>
    pad_din_en_o[8*$past(cfg_port_i)+:8] == $past(cfg_wdata_i[7:0]))
    else $error("enable write not applied to its port");
  a_ext_reset: assert property (ext_rst_i [*5] |=>
    pad_din_en_o == 64'h0000_0000_000F_0C3F && pad_pu_o == 64'h000F_0000)
    else $error("reset pin did not restore defaults");
endmodule : gpfs_top_assertions
bind gpfs_top gpfs_top_assertions #(.NPORT(NPORT), .NCODE(NCODE)) u_chk (
  .clk_i(clk_i), .srst_i(srst_i), .ext_rst_i(ext_rst_i),
  .cfg_we_i(cfg_we_i), .cfg_port_i(cfg_port_i), .cfg_reg_i(cfg_reg_i),
  .cfg_wdata_i(cfg_wdata_i), .pad_oe_o(pad_oe_o), .pad_pu_o(pad_pu_o),
  .pad_din_en_o(pad_din_en_o), .analog_en_o(analog_en_o),
  .periph_in_o(periph_in_o), .periph_oe_i(periph_oe_i),
  .periph_sel_o(periph_sel_o));

// File: dv/tb_gpio_pin_function_select.sv
/* Bench for gpfs_top: pin control model compared at every result.
   Stands alone with the far-side model. */
`timescale 1ns/1ps
module tb_gpio_pin_function_select;
  logic clk_i = 1'b0, srst_i = 1'b1, ext_rst_i = 1'b0, cfg_we_i = 1'b0;
  logic [2:0] cfg_port_i = 3'h0;
  gpfs_pkg::gpfs_reg_t cfg_reg_i = gpfs_pkg::GPFS_DATA;
  logic [7:0] cfg_mask_i = 8'h00, irq_o;
  logic [31:0] cfg_wdata_i = 32'h0, cfg_rdata_o;
  logic [63:0] lvl = '0, pad_in_i, pad_out_o, pad_oe_o, pad_pu_o, pad_pd_o;
  logic [63:0] pad_din_en_o, analog_en_o, periph_in_o;
  logic [15:0][63:0] periph_out_i, periph_oe_i, periph_sel_o;
  logic [63:0] m_af, m_dig, m_pu, m_pd, m_dir, m_dat;
  int m_code[64];
  int n_fail = 0, total_checks = 0;
  gpfs_top dut (.clk_i(clk_i), .srst_i(srst_i), .ext_rst_i(ext_rst_i),
    .cfg_we_i(cfg_we_i), .cfg_port_i(cfg_port_i), .cfg_reg_i(cfg_reg_i),
    .cfg_mask_i(cfg_mask_i), .cfg_wdata_i(cfg_wdata_i),
    .cfg_rdata_o(cfg_rdata_o), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o),
    .pad_oe_o(pad_oe_o), .pad_pu_o(pad_pu_o), .pad_pd_o(pad_pd_o),
    .pad_din_en_o(pad_din_en_o), .analog_en_o(analog_en_o),
    .periph_out_i(periph_out_i), .periph_oe_i(periph_oe_i),
    .periph_sel_o(periph_sel_o), .periph_in_o(periph_in_o), .irq_o(irq_o));
  gpfs_far_model u_far (.clk_i(clk_i), .lvl_i(lvl), .pad_in_o(pad_in_i),
    .per_out_o(periph_out_i), .per_oe_o(periph_oe_i));
  initial forever #4 clk_i = ~clk_i;
  task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize
  // Model defaults: serial pins code 1, debug pins code 3 with pull-up
  task automatic mreset();
    for (int p = 0; p < 64; p++) begin
      m_code[p] = (p < 6 || p inside {10, 11}) ? 1 :
                  (p inside {[16:19]}) ? 3 : 0;
      m_af[p] = m_code[p] != 0;
      m_dig[p] = m_af[p];
      m_pu[p] = m_code[p] == 3;
    end
    m_pd = '0;
    m_dir = '0;
    m_dat = '0;
  endtask : mreset
  // One write cycle, then the model follows
  task automatic wr(int p, gpfs_pkg::gpfs_reg_t r, logic [7:0] k, logic [31:0] d);
    @(posedge clk_i);
    cfg_we_i <= 1'b1;
    cfg_port_i <= 3'(p);
    cfg_reg_i <= r;
    cfg_mask_i <= k;
    cfg_wdata_i <= d;
    @(posedge clk_i);
    cfg_we_i <= 1'b0;
    for (int b = 0; b < 8; b++) begin
      case (r)
        gpfs_pkg::GPFS_AFSEL: m_af[p*8+b] = d[b];
        gpfs_pkg::GPFS_DIGEN: m_dig[p*8+b] = d[b];
        gpfs_pkg::GPFS_PUP: m_pu[p*8+b] = d[b];
        gpfs_pkg::GPFS_PDN: m_pd[p*8+b] = d[b];
        gpfs_pkg::GPFS_DIR: m_dir[p*8+b] = d[b];
        gpfs_pkg::GPFS_DATA: if (k[b]) m_dat[p*8+b] = d[b];
        gpfs_pkg::GPFS_PCTL: m_code[p*8+b] = int'(d[4*b+:4]);
        default: ;
      endcase
    end
    @(negedge clk_i);
  endtask : wr
  // Read one register; the answer stands one cycle after the address
  task automatic rd(int p, gpfs_pkg::gpfs_reg_t r);
    @(posedge clk_i);
    cfg_port_i <= 3'(p);
    cfg_reg_i <= r;
    cfg_mask_i <= 8'hFF;
    @(posedge clk_i);
    @(negedge clk_i);
  endtask : rd
  // Every pad output against the model
  task automatic cmp_all();
    logic [63:0] pl, e, eo, ed;
    pl = ~m_af & m_dig;
    eo = m_dir & pl;
    ed = m_dat & pl;
    for (int c = 0; c < 16; c++) begin
      for (int p = 0; p < 64; p++)
        e[p] = m_af[p] && m_dig[p] && m_code[p] == c;
      chk("sel", e, periph_sel_o[c]);
      chk("route", e & periph_oe_i[c], e & pad_oe_o);
      eo |= e & periph_oe_i[c];
      ed |= e & periph_out_i[c];
    end
    chk("din_en", m_dig, pad_din_en_o);
    chk("analog", ~m_dig, analog_en_o);
    chk("pull_up", m_pu, pad_pu_o);
    chk("pull_dn", m_pd, pad_pd_o);
    chk("oe", eo, pad_oe_o);
    chk("out", ed, pad_out_o);
    chk("pin_in", lvl & m_dig, periph_in_o);
  endtask : cmp_all
  initial begin
    repeat (5000) @(posedge clk_i);
    n_fail++;
    summarize();
  end
  initial begin
    logic [7:0] k, pv;
    int b, cd;
    bit [3:0] mt [5] = '{4'h3, 4'h0, 4'h5, 4'hB, 4'h8};
    void'($urandom(39));
    mreset();
    repeat (20) @(posedge clk_i);
    srst_i <= 1'b0;
    @(negedge clk_i);
    cmp_all();
    wr(3, gpfs_pkg::GPFS_DIGEN, 8'hFF, 32'hFF);
    wr(3, gpfs_pkg::GPFS_DIR, 8'hFF, 32'hFF);
    wr(3, gpfs_pkg::GPFS_PDN, 8'h00, 32'($urandom));
    wr(3, gpfs_pkg::GPFS_PUP, 8'h00, 32'($urandom));
    for (int i = 0; i < 4; i++) begin
      k = 8'($urandom);
      pv = m_dat[31:24];
      wr(3, gpfs_pkg::GPFS_DATA, k, i[0] ? 32'h0 : 32'hFF);
      cmp_all();
      chk("read", 64'(pv & k), 64'(cfg_rdata_o));
    end
    for (int i = 0; i < 4; i++) begin
      b = $urandom_range(7);
      cd = $urandom_range(15);
      wr(4, gpfs_pkg::GPFS_PCTL, 8'h00, 32'(cd) << 4 * b);
      wr(4, gpfs_pkg::GPFS_AFSEL, 8'h00, 32'h1 << b);
      wr(4, gpfs_pkg::GPFS_DIGEN, 8'h00, 32'($urandom));
      cmp_all();
      rd(4, gpfs_pkg::GPFS_PCTL);
      chk("pctl", 64'(32'(cd) << 4 * b), 64'(cfg_rdata_o));
      wr(4, gpfs_pkg::GPFS_DIGEN, 8'h00, 32'h0);
      cmp_all();
    end
    wr(5, gpfs_pkg::GPFS_DIGEN, 8'h00, 32'h1);
    wr(5, gpfs_pkg::GPFS_IMASK, 8'h00, 32'h1);
    for (int m = 0; m <= 5; m++) begin
      if (m == 5) wr(5, gpfs_pkg::GPFS_IMASK, 8'h00, 32'h0);
      @(posedge clk_i) lvl[40] <= 1'b0;
      wr(5, gpfs_pkg::GPFS_ISENSE, 8'h00, 32'(mt[m % 5][3]));
      wr(5, gpfs_pkg::GPFS_IBOTH, 8'h00, 32'(mt[m % 5][2]));
      wr(5, gpfs_pkg::GPFS_IEVENT, 8'h00, 32'(mt[m % 5][1]));
      repeat (8) @(posedge clk_i);
      wr(5, gpfs_pkg::GPFS_ICLR, 8'h00, 32'h1);
      @(posedge clk_i) lvl[40] <= 1'b1;
      repeat (10) @(posedge clk_i);
      @(negedge clk_i);
      chk("irq", 64'(mt[m % 5][0] && m < 5), 64'(irq_o[5]));
      rd(5, gpfs_pkg::GPFS_IMSK);
      chk("irq_msk", 64'(mt[m % 5][0] && m < 5), 64'(cfg_rdata_o));
    end
    @(posedge clk_i) ext_rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    ext_rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    mreset();
    cmp_all();
    summarize();
  end
endmodule : tb_gpio_pin_function_select
